// *** rtl/cab_alu_bit_branch.sv ***
`timescale 1ns/1ps
module cab_alu_bit_branch
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  input wire logic [7:0] zp_data,
  input wire logic [7:0] mx_data,
  input wire logic [7:0] rel_disp,
  input wire logic [7:0] x_index,
  output logic [7:0] acc,
  output logic [7:0] status,
  output logic [15:0] pc,
  output logic mem_we,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic busy,
  output logic done,
  output logic illegal
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    CAB_IDLE = 2'b00,
    CAB_EXEC = 2'b01
  } cab_state_t;

  cab_state_t state;
  logic [2:0] cyc_left;

  function automatic logic is_bb(input logic [7:0] op, input logic [4:0] lo);
    is_bb = (op[4:0] & cab_pkg::BB_LOW_MASK & 5'h0F) == (lo & 5'h0F)
      && op[3:0] == lo[3:0];
  endfunction : is_bb

  logic bb_a;
  logic bb_zp;
  logic [2:0] bit_idx;
  logic bb_clear;
  logic [7:0] bb_src;
  logic bb_taken;
  logic t_flag;

  assign t_flag = status[5];
  assign bb_a = is_bb(opcode, cab_pkg::BB_LOW_A);
  assign bb_zp = is_bb(opcode, cab_pkg::BB_LOW_ZP);
  assign bit_idx = opcode[7:5];
  assign bb_clear = opcode[cab_pkg::BB_CLEAR_BIT];
  assign bb_src = bb_a ? acc : zp_data;
  assign bb_taken = bb_clear ? ~bb_src[bit_idx]
                             : bb_src[bit_idx];

  // ---------------------------------------------------------------
  // alu
  // ---------------------------------------------------------------
  logic [7:0] m_val;
  logic [7:0] dst_val;
  logic [8:0] sum;
  logic [7:0] res;
  logic next_c;
  logic next_v;
  logic to_mem;
  logic to_acc;
  logic flags_c;
  logic flags_v;
  logic known;
  logic [2:0] cycles;
  logic [1:0] len;

  always_comb
  begin
    m_val = (opcode == cab_pkg::OP_ADC_IMM
      || opcode == cab_pkg::OP_AND_IMM) ? operand : zp_data;
    dst_val = t_flag ? mx_data : acc;
    sum = 9'h000;
    res = 8'h00;
    next_c = status[cab_pkg::PS_C];
    next_v = status[cab_pkg::PS_V];
    to_mem = 1'b0;
    to_acc = 1'b0;
    flags_c = 1'b0;
    flags_v = 1'b0;
    known = 1'b1;
    cycles = cab_pkg::CYC_IMM;
    len = cab_pkg::LEN_2;
    case (opcode)
      cab_pkg::OP_ADC_IMM, cab_pkg::OP_ADC_ZP:
      begin
        sum = {1'b0, dst_val} + {1'b0, m_val}
          + {8'h00, status[cab_pkg::PS_C]};
        res = sum[7:0];
        next_c = sum[8];
        next_v = (dst_val[7] == m_val[7]) && (res[7] != m_val[7]);
        to_mem = t_flag;
        to_acc = ~t_flag;
        flags_c = 1'b1;
        flags_v = 1'b1;
      end
      cab_pkg::OP_AND_IMM, cab_pkg::OP_AND_ZP:
      begin
        res = dst_val & m_val;
        to_mem = t_flag;
        to_acc = ~t_flag;
      end
      cab_pkg::OP_ASL_A, cab_pkg::OP_ASL_ZP:
      begin
        res = (opcode == cab_pkg::OP_ASL_A) ? {acc[6:0], 1'b0}
          : {zp_data[6:0], 1'b0};
        next_c = (opcode == cab_pkg::OP_ASL_A) ? acc[7]
          : zp_data[7];
        to_acc = (opcode == cab_pkg::OP_ASL_A);
        to_mem = ~to_acc;
        flags_c = 1'b1;
      end
      default:
      begin
        known = bb_a | bb_zp;
      end
    endcase
    // cycle and length table
    if (opcode == cab_pkg::OP_ADC_ZP || opcode == cab_pkg::OP_AND_ZP)
      cycles = cab_pkg::CYC_ZP_ALU;
    else if (opcode == cab_pkg::OP_ASL_A)
    begin
      cycles = cab_pkg::CYC_ASL_A;
      len = cab_pkg::LEN_1;
    end
    else if (opcode == cab_pkg::OP_ASL_ZP)
      cycles = cab_pkg::CYC_ASL_ZP;
    else if (bb_a)
      cycles = cab_pkg::CYC_BB_A;
    else if (bb_zp)
    begin
      cycles = cab_pkg::CYC_BB_ZP;
      len = cab_pkg::LEN_3;
    end
  end

  // ---------------------------------------------------------------
  // sequencing: result commits on the last cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= CAB_IDLE;
      cyc_left <= 3'h0;
      busy <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      illegal <= 1'b0;
      case (state)
        CAB_IDLE:
        begin
          if (start && known)
          begin
            state <= CAB_EXEC;
            cyc_left <= cycles - 3'h1;
            busy <= 1'b1;
          end
          else if (start)
            illegal <= 1'b1;
        end
        CAB_EXEC:
        begin
          if (cyc_left == 3'h1)
          begin
            state <= CAB_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end
          cyc_left <= cyc_left - 3'h1;
        end
        default:
          state <= CAB_IDLE;
      endcase
    end
  end

  // operands are expected stable from start until done
  logic commit;
  assign commit = (state == CAB_EXEC) && (cyc_left == 3'h1);

  // ---------------------------------------------------------------
  // architectural state
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc <= 8'h00;
      status <= cab_pkg::PS_RESET;
    end
    else if (commit && !(bb_a || bb_zp))
    begin
      if (to_acc)
        acc <= res;
      status[cab_pkg::PS_N] <= res[7];
      status[cab_pkg::PS_Z] <= (res == 8'h00);
      if (flags_c)
        status[cab_pkg::PS_C] <= next_c;
      if (flags_v)
        status[cab_pkg::PS_V] <= next_v;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pc <= cab_pkg::PC_RESET;
    else if (commit)
    begin
      if ((bb_a || bb_zp) && bb_taken)
        pc <= pc + {14'h0000, len}
          + {{8{rel_disp[7]}}, rel_disp};
      else
        pc <= pc + {14'h0000, len};
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mem_we <= 1'b0;
      mem_addr <= 8'h00;
      mem_wdata <= 8'h00;
    end
    else
    begin
      mem_we <= commit && to_mem && !(bb_a || bb_zp);
      if (commit && to_mem)
      begin
        // t set targets m(x); asl targets the zero-page operand
        mem_addr <= (opcode == cab_pkg::OP_ASL_ZP) ? operand : x_index;
        mem_wdata <= res;
      end
    end
  end
endmodule : cab_alu_bit_branch

// *** shared/cab_pkg.sv ***
package cab_pkg;
  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_ADC_IMM = 8'h69;
  localparam logic [7:0] OP_ADC_ZP = 8'h65;
  localparam logic [7:0] OP_AND_IMM = 8'h29;
  localparam logic [7:0] OP_AND_ZP = 8'h25;
  localparam logic [7:0] OP_ASL_A = 8'h0A;
  localparam logic [7:0] OP_ASL_ZP = 8'h06;
  // bit-branch bases; bit index i adds 8'h20 * i
  localparam logic [7:0] OP_BBS_A = 8'h03;
  localparam logic [7:0] OP_BBC_A = 8'h13;
  localparam logic [7:0] OP_BBS_ZP = 8'h07;
  localparam logic [7:0] OP_BBC_ZP = 8'h17;
  localparam logic [4:0] BB_LOW_MASK = 5'h1F;
  localparam logic [4:0] BB_LOW_A = 5'h03;
  localparam logic [4:0] BB_LOW_ZP = 5'h07;
  localparam int BB_CLEAR_BIT = 4;
  // ---------------------------------------------------------------
  // cycle counts per instruction
  // ---------------------------------------------------------------
  localparam logic [2:0] CYC_IMM = 3'h2;
  localparam logic [2:0] CYC_ZP_ALU = 3'h3;
  localparam logic [2:0] CYC_ASL_A = 3'h2;
  localparam logic [2:0] CYC_ASL_ZP = 3'h5;
  localparam logic [2:0] CYC_BB_A = 3'h4;
  localparam logic [2:0] CYC_BB_ZP = 3'h5;
  // instruction lengths in bytes
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  // ---------------------------------------------------------------
  // status register bit positions
  // ---------------------------------------------------------------
  localparam int PS_C = 0;
  localparam int PS_Z = 1;
  localparam int PS_V = 6;
  localparam int PS_N = 7;
  localparam logic [7:0] PS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
endpackage : cab_pkg

// *** testbench/cab_chk.sv ***
`timescale 1ns/1ps
module cab_chk
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  input wire logic [7:0] rel_disp,
  input wire logic [7:0] acc,
  input wire logic [7:0] status,
  input wire logic [15:0] pc,
  input wire logic mem_we,
  input wire logic busy,
  input wire logic done,
  input wire logic illegal
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // timing and results
  // ----------------------------------------
  sequence taken;
    start && !busy;
  endsequence
  imm_time_a: assert property (taken ##0 (opcode == 8'h69 ||
    opcode == 8'h29 || opcode == 8'h0A) |-> ##2 done) else $error("imm time");
  zp_time_a: assert property (taken ##0 (opcode == 8'h65 ||
    opcode == 8'h25) |-> ##3 done) else $error("zp time");
  shift_zp_time_a: assert property (taken ##0 opcode == 8'h06
    |-> ##5 done) else $error("shift zp time");
  bb_time_a: assert property (taken ##0 opcode[3:0] == 4'h3
    |-> ##4 done) else $error("branch time");
  bad_op_a: assert property (taken ##0 opcode == 8'hFF |=> illegal)
    else $error("no illegal");
  we_after_a: assert property (mem_we |-> done && opcode == 8'h06)
    else $error("write timing");
  shift_acc_a: assert property (done && opcode == 8'h0A |->
    acc == {$past(acc[6:0]), 1'b0} && status[0] == $past(acc[7]))
    else $error("shift result");
  add_imm_a: assert property (done && opcode == 8'h69 |->
    {status[0], acc} == 9'($past(acc)) + 9'(operand) + 9'($past(status[0])))
    else $error("add result");
  branch_pc_a: assert property (done && opcode[3:0] == 4'h3 |->
    pc == $past(pc) + 16'h2 + ((acc[opcode[7:5]] ^ opcode[4]) ?
    {{8{rel_disp[7]}}, rel_disp} : 16'h0)) else $error("branch pc");
  bb_zp_time_a: assert property (taken ##0 opcode[3:0] == 4'h7
    |-> ##5 done) else $error("zero page branch time");
  nz_flags_a: assert property (done && (opcode == 8'h69 ||
    opcode == 8'h65 || opcode == 8'h29 || opcode == 8'h25 ||
    opcode == 8'h0A) |-> status[7] == acc[7] &&
    status[1] == (acc == 8'h00)) else $error("flag result");
  bb_flags_a: assert property (done && (opcode[3:0] == 4'h3 ||
    opcode[3:0] == 4'h7) |-> status == $past(status) && acc == $past(acc))
    else $error("branch changed state");
  busy_span_a: assert property (taken ##0 opcode[3:0] == 4'h3
    |=> busy [*3] ##1 !busy) else $error("busy span");
endmodule : cab_chk
bind cab_alu_bit_branch cab_chk u_chk (.clk, .rst, .start, .opcode,
  .operand, .rel_disp, .acc, .status, .pc, .mem_we, .busy, .done, .illegal);

// *** testbench/cab_mem.sv ***
`timescale 1ns/1ps
module cab_mem
(
  input wire logic clk,
  input wire logic [7:0] operand,
  input wire logic [7:0] x_index,
  input wire logic mem_we,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] zp_data,
  output logic [7:0] mx_data
);
  logic [7:0] mem [256];
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i * 37 + 5);
  end
  // reads are combinational, so data is steady for the whole instruction
  assign zp_data = mem[operand];
  assign mx_data = mem[x_index];
  always @(posedge clk)
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
endmodule : cab_mem

// *** testbench/test_cab_alu_bit_branch.sv ***
`timescale 1ns/1ps
module test_cab_alu_bit_branch;
  logic clk = 0, rst = 1, start = 0, ec = 0, bit_v;
  logic [7:0] opcode = 0, operand = 0, rel_disp = 0, x_index = 0;
  logic [7:0] zp_data, mx_data, acc, status, mem_addr, mem_wdata, ea = 0;
  logic [15:0] pc, epc = 0;
  logic mem_we, busy, done, illegal;
  logic [24:0] expq [$];
  logic [7:0] ops [7] = '{8'h69, 8'h65, 8'h29, 8'h25, 8'h0A, 8'h06, 8'hFF};
  int bad_count = 0, compares = 0, cycles = 0;
  always #12.5 clk = ~clk;
  cab_alu_bit_branch u_dut (.clk, .rst, .start, .opcode, .operand,
    .zp_data, .mx_data, .rel_disp, .x_index, .acc, .status, .pc,
    .mem_we, .mem_addr, .mem_wdata, .busy, .done, .illegal);
  cab_mem u_mem (.clk, .operand, .x_index, .mem_we, .mem_addr,
    .mem_wdata, .zp_data, .mx_data);
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic check(input logic [24:0] g, input logic [24:0] w);
    compares++;
    if (g !== w)
    begin
      bad_count++;
      $display("Error at %0t got %h want %h", $time, g, w);
    end
  endtask : check
  // ----------------------------------------
  // result monitor
  // ----------------------------------------
  always @(negedge clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      bad_count++;
      conclude();
    end
    else if (done === 1'b1)
      check({status[0], pc, acc}, expq.pop_front());
  end
  task automatic run(input logic [7:0] op, input logic [7:0] opd,
    input logic [7:0] d);
    logic [7:0] m;
    logic [1:0] len;
    m = (op == 8'h69 || op == 8'h29) ? opd : u_mem.mem[opd];
    len = (op == 8'h0A) ? 2'h1 : (op[3:0] == 4'h7) ? 2'h3 : 2'h2;
    bit_v = (op[3:0] == 4'h3) ? ea[op[7:5]] : m[op[7:5]];
    if (op == 8'h69 || op == 8'h65)
      {ec, ea} = 9'(ea) + 9'(m) + 9'(ec);
    if (op == 8'h29 || op == 8'h25)
      ea = ea & m;
    if (op == 8'h0A)
      {ec, ea} = {ea, 1'b0};
    if (op == 8'h06)
      ec = m[7];
    if (op != 8'hFF)
      epc = epc + 16'(len);
    if ((op[3:0] == 4'h3 || op[3:0] == 4'h7) && (bit_v ^ op[4]))
      epc = epc + {{8{d[7]}}, d};
    @(negedge clk);
    start = 1;
    opcode = op;
    operand = opd;
    rel_disp = d;
    x_index = 8'($urandom);
    if (op != 8'hFF)
      expq.push_back({ec, epc, ea});
    @(negedge clk);
    start = 0;
    if (op == 8'hFF)
      check(25'(illegal), 25'h1);
    for (int i = 0; i < 8 && op != 8'hFF && done !== 1'b1; i++)
      @(negedge clk);
    if (op == 8'h06)
    begin
      repeat (2) @(negedge clk);
      check(25'(u_mem.mem[opd]), 25'({m[6:0], 1'b0}));
    end
  endtask : run
  initial
  begin
    void'($urandom(57));
    repeat (2) @(negedge clk);
    rst = 0;
    for (int k = 0; k < 3; k++)
    begin
      foreach (ops[j])
        run(ops[j], 8'($urandom), 8'($urandom));
      for (logic [5:0] b = 0; b < 32; b++)
        run({b[2:0], b[3], 1'b0, b[4], 2'h3}, 8'($urandom),
          8'($urandom));
    end
    repeat (4) @(negedge clk);
    conclude();
  end
endmodule : test_cab_alu_bit_branch
